/* verilog/ipsu_top.sv */
`timescale 1ns/10ps
`include "ipsu_consts.svh"

module ipsu_top #(
    parameter int STACK_DEPTH = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire ipsu_pkg::ipsu_axi_req_s axi_req,
    output ipsu_pkg::ipsu_axi_rsp_s axi_rsp,
    input wire logic [ipsu_pkg::IPSU_N_SRC-1:0] src_event,
    input wire logic [ipsu_pkg::IPSU_N_TRAP-1:0] trap_event,
    input wire logic cpu_ack,
    input wire logic cpu_return,
    output ipsu_pkg::ipsu_cpu_req_s cpu_req,
    output logic [3:0] cpu_level,
    output logic irq
);
    import ipsu_pkg::*;

    localparam int DW = $clog2(STACK_DEPTH + 1);

    if (STACK_DEPTH < 1 || STACK_DEPTH > 64)
    begin : g_bad_depth
        $error("ipsu_top: STACK_DEPTH must lie in 1..64");
    end

    // the vector table and priority register serve two sources; trap levels must fit four bits
    if (IPSU_N_SRC != 2 || IPSU_N_TRAP < 1 || IPSU_N_TRAP > 8)
    begin : g_bad_counts
        $error("ipsu_top: source or trap count not served");
    end

    typedef struct packed {
        ipsu_axi_rsp_s axi;
        ipsu_cpu_req_s req;
        logic irq;
        logic [2:0] capture9_priority;
        logic [2:0] compare9_priority;
        logic [IPSU_N_SRC-1:0] flags;
        logic [IPSU_N_SRC-1:0] enables;
        logic [IPSU_N_TRAP-1:0] trap_flags;
        logic nesting_disable;
        logic vector_capture_mode;
        logic [3:0] level;
        logic [4:0] srl_low;
        logic [6:0] last_ack;
        logic [13:0] timed_irq_disable_instr_cnt;
        logic [DW-1:0] depth;
        ipsu_frame_s [STACK_DEPTH-1:0] stack;
    } ipsu_state_s;

    ipsu_state_s st_r;
    ipsu_state_s st_nxt;

    function automatic logic [7:0] src_vector(input int idx);
        src_vector = (idx == 0) ? `IPSU_VEC_CAP9 : `IPSU_VEC_CMP9;
    endfunction : src_vector

    always_comb
    begin
        logic [2:0] prio [IPSU_N_SRC];
        logic [2:0] best_p;
        logic [7:0] best_v;
        logic [3:0] user_lvl;
        logic [3:0] trap_lvl;
        logic [7:0] trap_vec;
        logic any_pend;
        logic user_go;
        logic trap_go;
        logic [31:0] wmask;
        logic [31:0] wd;
        logic [31:0] rd;
        logic hit;
        logic [IPSU_N_SRC-1:0] flag_clr;
        logic [IPSU_N_TRAP-1:0] trap_clr;
        st_nxt = st_r;
        prio[0] = st_r.capture9_priority;
        prio[1] = st_r.compare9_priority;
        best_p = 3'h0;
        best_v = 8'hFF;
        any_pend = 1'b0;
        trap_lvl = 4'h0;
        trap_vec = 8'h00;
        flag_clr = '0;
        trap_clr = '0;
        rd = 32'h0000_0000;
        wmask = 32'h0000_0000;
        wd = 32'h0000_0000;
        user_lvl = 4'h0;
        user_go = 1'b0;
        trap_go = 1'b0;
        hit = 1'b1;

        // arbitration among armed user sources
        for (int i = 0; i < IPSU_N_SRC; i++)
        begin
            if (st_r.flags[i] && st_r.enables[i] && prio[i] != 3'h0)
            begin
                any_pend = 1'b1;
                if (prio[i] > best_p || (prio[i] == best_p && src_vector(i) < best_v))
                begin
                    best_p = prio[i];
                    best_v = src_vector(i);
                end
            end
        end

        // user sources see the cpu level, raised by a timed disable, or raised to 4'hF by nesting disable while nested
        user_lvl = st_r.level;
        if (st_r.timed_irq_disable_instr_cnt != 14'h0000 && user_lvl < `IPSU_TIMED_IRQ_DISABLE_INSTR_LVL)
        begin
            user_lvl = `IPSU_TIMED_IRQ_DISABLE_INSTR_LVL;
        end
        if (st_r.nesting_disable && st_r.depth != '0)
        begin
            user_lvl = 4'hF;
        end
        user_go = any_pend && ({1'b0, best_p} > user_lvl);

        // traps ignore the timed disable and nesting disable, but must exceed the cpu level
        for (int t = 0; t < IPSU_N_TRAP; t++)
        begin
            if (st_r.trap_flags[t])
            begin
                trap_lvl = `IPSU_TRAP_BASE_LVL + 4'(t);
                trap_vec = `IPSU_VEC_TRAP0 + 8'(t);
            end
        end
        trap_go = st_r.trap_flags != '0 && trap_lvl > st_r.level;

        if (trap_go)
        begin
            st_nxt.req = '{valid: 1'b1, vector: trap_vec, level: trap_lvl};
        end
        else if (user_go)
        begin
            st_nxt.req = '{valid: 1'b1, vector: best_v, level: {1'b0, best_p}};
        end
        else
        begin
            st_nxt.req = '{valid: 1'b0, vector: 8'h00, level: 4'h0};
        end

        // core handshake: the acknowledged level becomes the new cpu level
        if (cpu_ack && st_r.req.valid && st_r.depth < DW'(STACK_DEPTH))
        begin
            st_nxt.stack[st_r.depth] = '{level: st_r.level, srl_low: st_r.srl_low};
            st_nxt.depth = st_r.depth + DW'(1);
            st_nxt.level = st_r.req.level;
            if (st_r.req.vector >= `IPSU_VEC_BASE)
            begin
                st_nxt.last_ack = 7'(st_r.req.vector - `IPSU_VEC_BASE);
            end
        end
        else if (cpu_return && st_r.depth != '0)
        begin
            // flags are untouched, so a source left set is offered again
            st_nxt.depth = st_r.depth - DW'(1);
            st_nxt.level = st_r.stack[st_r.depth - DW'(1)].level;
            st_nxt.srl_low = st_r.stack[st_r.depth - DW'(1)].srl_low;
        end

        if (st_r.timed_irq_disable_instr_cnt != 14'h0000)
        begin
            st_nxt.timed_irq_disable_instr_cnt = st_r.timed_irq_disable_instr_cnt - 14'h0001;
        end

        // register write, in the cycle the address and data are taken
        for (int b = 0; b < 4; b++)
        begin
            wmask[b*8 +: 8] = {8{axi_req.wstrb[b]}};
        end
        wd = axi_req.wdata & wmask;
        st_nxt.axi.awready = 1'b0;
        st_nxt.axi.wready = 1'b0;
        st_nxt.axi.arready = 1'b0;
        if (st_r.axi.bvalid && axi_req.bready)
        begin
            st_nxt.axi.bvalid = 1'b0;
        end
        if (st_r.axi.awready)
        begin
            case (axi_req.awaddr)
                `IPSU_OFF_PRIO:
                begin
                    if (axi_req.wstrb[0])
                    begin
                        st_nxt.capture9_priority = wd[`IPSU_CAP9_LSB +: 3];
                        st_nxt.compare9_priority = wd[`IPSU_CMP9_LSB +: 3];
                    end
                end
                `IPSU_OFF_STATUS:
                begin
                    if (axi_req.wstrb[1])
                    begin
                        st_nxt.vector_capture_mode = wd[`IPSU_ST_VECTOR_CAPTURE_MODE_BIT];
                    end
                end
                `IPSU_OFF_FLAGS: flag_clr = wd[IPSU_N_SRC-1:0];
                `IPSU_OFF_ENABLE:
                begin
                    if (axi_req.wstrb[0])
                    begin
                        st_nxt.enables = wd[IPSU_N_SRC-1:0];
                    end
                end
                `IPSU_OFF_CTRL1:
                begin
                    trap_clr = wd[`IPSU_C1_TRAP_LSB +: IPSU_N_TRAP];
                    if (axi_req.wstrb[1])
                    begin
                        st_nxt.nesting_disable = wd[`IPSU_C1_NEST_BIT];
                    end
                end
                `IPSU_OFF_SRL:
                begin
                    if (axi_req.wstrb[0])
                    begin
                        st_nxt.level = {1'b0, wd[`IPSU_SRL_LVL_LSB +: 3]};
                        st_nxt.srl_low = wd[4:0];
                    end
                end
                `IPSU_OFF_TIMED_IRQ_DISABLE_INSTR:
                begin
                    if (axi_req.wstrb[1:0] == 2'b11)
                    begin
                        st_nxt.timed_irq_disable_instr_cnt = wd[13:0];
                    end
                end
                default: hit = 1'b0;
            endcase
            st_nxt.axi.bvalid = 1'b1;
            st_nxt.axi.bresp = hit ? `IPSU_RESP_OKAY : `IPSU_RESP_SLVERR;
        end
        else if (axi_req.awvalid && axi_req.wvalid && !st_r.axi.bvalid)
        begin
            st_nxt.axi.awready = 1'b1;
            st_nxt.axi.wready = 1'b1;
        end

        // an event in the clearing cycle survives: set is applied last
        st_nxt.flags = (st_r.flags & ~flag_clr) | src_event;
        st_nxt.trap_flags = (st_r.trap_flags & ~trap_clr) | trap_event;
        st_nxt.irq = |(st_r.flags & st_r.enables);

        if (st_r.axi.rvalid && axi_req.rready)
        begin
            st_nxt.axi.rvalid = 1'b0;
        end
        if (st_r.axi.arready)
        begin
            hit = 1'b1;
            case (axi_req.araddr)
                `IPSU_OFF_PRIO:
                begin
                    rd[`IPSU_CAP9_LSB +: 3] = st_r.capture9_priority;
                    rd[`IPSU_CMP9_LSB +: 3] = st_r.compare9_priority;
                end
                `IPSU_OFF_STATUS:
                begin
                    rd[`IPSU_ST_REQ_BIT] = any_pend && !user_go;
                    rd[`IPSU_ST_VECTOR_CAPTURE_MODE_BIT] = st_r.vector_capture_mode;
                    rd[`IPSU_ST_ILR_LSB +: 4] = st_r.level;
                    if (st_r.vector_capture_mode && any_pend)
                    begin
                        rd[`IPSU_ST_VEC_LSB +: 7] = 7'(best_v - `IPSU_VEC_BASE);
                    end
                    else if (!st_r.vector_capture_mode)
                    begin
                        rd[`IPSU_ST_VEC_LSB +: 7] = st_r.last_ack;
                    end
                end
                `IPSU_OFF_FLAGS: rd[IPSU_N_SRC-1:0] = st_r.flags;
                `IPSU_OFF_ENABLE: rd[IPSU_N_SRC-1:0] = st_r.enables;
                `IPSU_OFF_CTRL1:
                begin
                    rd[`IPSU_C1_NEST_BIT] = st_r.nesting_disable;
                    rd[`IPSU_C1_TRAP_LSB +: IPSU_N_TRAP] = st_r.trap_flags;
                end
                `IPSU_OFF_SRL:
                begin
                    // a trap level shows as all three level bits set
                    rd[`IPSU_SRL_LVL_LSB +: 3] = st_r.level[3] ? 3'h7 : st_r.level[2:0];
                    rd[4:0] = st_r.srl_low;
                end
                `IPSU_OFF_TIMED_IRQ_DISABLE_INSTR: rd[13:0] = st_r.timed_irq_disable_instr_cnt;
                default: hit = 1'b0;
            endcase
            st_nxt.axi.rvalid = 1'b1;
            st_nxt.axi.rdata = rd;
            st_nxt.axi.rresp = hit ? `IPSU_RESP_OKAY : `IPSU_RESP_SLVERR;
        end
        else if (axi_req.arvalid && !st_r.axi.rvalid)
        begin
            st_nxt.axi.arready = 1'b1;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_r <= '0;
            st_r.capture9_priority <= `IPSU_PRIO_RST;
            st_r.compare9_priority <= `IPSU_PRIO_RST;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign axi_rsp = st_r.axi;
    assign cpu_req = st_r.req;
    assign cpu_level = st_r.level;
    assign irq = st_r.irq;

endmodule : ipsu_top

/* verilog/ipsu_consts.svh */
`ifndef IPSU_CONSTS_SVH
`define IPSU_CONSTS_SVH

// register byte offsets
`define IPSU_OFF_PRIO 8'h00
`define IPSU_OFF_STATUS 8'h04
`define IPSU_OFF_FLAGS 8'h08
`define IPSU_OFF_ENABLE 8'h0C
`define IPSU_OFF_CTRL1 8'h10
`define IPSU_OFF_SRL 8'h14
`define IPSU_OFF_TIMED_IRQ_DISABLE_INSTR 8'h18

// priority register fields
`define IPSU_CAP9_LSB 4
`define IPSU_CMP9_LSB 0
`define IPSU_PRIO_MASK 16'h0077
`define IPSU_PRIO_RST 3'h4

// status register fields
`define IPSU_ST_REQ_BIT 15
`define IPSU_ST_VECTOR_CAPTURE_MODE_BIT 13
`define IPSU_ST_ILR_LSB 8
`define IPSU_ST_VEC_LSB 0

// control register one fields
`define IPSU_C1_NEST_BIT 15
`define IPSU_C1_TRAP_LSB 1

// status low byte: cpu level bits sit at 7:5
`define IPSU_SRL_LVL_LSB 5
`define IPSU_USER_MAX_LVL 4'h7
`define IPSU_TIMED_IRQ_DISABLE_INSTR_LVL 4'h6
`define IPSU_TRAP_BASE_LVL 4'h8
`define IPSU_VEC_BASE 8'h08

// vector numbers of the two sources and the traps, chosen values
`define IPSU_VEC_CAP9 8'h35
`define IPSU_VEC_CMP9 8'h36
`define IPSU_VEC_TRAP0 8'h02

`define IPSU_RESP_OKAY 2'h0
`define IPSU_RESP_SLVERR 2'h2

`endif

/* verilog/ipsu_pkg.sv */
package ipsu_pkg;

    localparam int IPSU_N_SRC = 2;
    localparam int IPSU_N_TRAP = 4;

    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } ipsu_axi_req_s;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } ipsu_axi_rsp_s;

    // request offered to the core
    typedef struct packed {
        logic valid;
        logic [7:0] vector;
        logic [3:0] level;
    } ipsu_cpu_req_s;

    // one stacked context: level and low status bits in force before entry
    typedef struct packed {
        logic [3:0] level;
        logic [4:0] srl_low;
    } ipsu_frame_s;

endpackage : ipsu_pkg

/* bench/ipsu_assertions.sv */
`timescale 1ns/10ps
module ipsu_assertions (
    input wire logic aclk,
    input wire logic aresetn,
    input wire ipsu_pkg::ipsu_axi_req_s axi_req,
    input wire ipsu_pkg::ipsu_axi_rsp_s axi_rsp,
    input wire logic cpu_ack,
    input wire logic cpu_return,
    input wire ipsu_pkg::ipsu_cpu_req_s cpu_req,
    input wire logic [3:0] cpu_level
);
    import ipsu_pkg::*;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_write_answer: assert property (
        $rose(axi_req.awvalid) |-> ##1 (axi_rsp.awready && axi_rsp.wready) ##1 axi_rsp.bvalid)
        else $error("write answer late or missing");
    a_read_answer: assert property (
        $rose(axi_req.arvalid) |-> ##1 axi_rsp.arready ##1 axi_rsp.rvalid)
        else $error("read answer late or missing");
    a_upper_zero: assert property (
        axi_rsp.rvalid |-> axi_rsp.rdata[31:16] == 16'h0000)
        else $error("upper read bits not zero");
    a_offer_above_level: assert property (
        cpu_req.valid |-> cpu_req.level > $past(cpu_level))
        else $error("request offered at or below cpu level");
    a_ack_sets_level: assert property (
        cpu_ack && cpu_req.valid |=> cpu_level == $past(cpu_req.level))
        else $error("ack did not raise cpu level");
    a_trap_vector: assert property (
        cpu_req.valid && cpu_req.level[3] |-> cpu_req.vector == {4'h0, cpu_req.level} - 8'h06)
        else $error("trap vector does not match level");
    a_user_vector: assert property (
        cpu_req.valid && !cpu_req.level[3] |-> cpu_req.vector inside {8'h35, 8'h36})
        else $error("user request with bad vector");
    a_level_holds: assert property (
        !cpu_ack && !cpu_return && !axi_req.awvalid |=> $stable(cpu_level))
        else $error("cpu level moved without cause");
    a_return_lowers: assert property (
        cpu_return && !cpu_ack && cpu_level != 4'h0 |=> cpu_level < $past(cpu_level))
        else $error("return did not restore lower level");
endmodule : ipsu_assertions

bind ipsu_top ipsu_assertions i_chk (
    .aclk(aclk),
    .aresetn(aresetn),
    .axi_req(axi_req),
    .axi_rsp(axi_rsp),
    .cpu_ack(cpu_ack),
    .cpu_return(cpu_return),
    .cpu_req(cpu_req),
    .cpu_level(cpu_level)
);

/* bench/ipsu_core_model.sv */
`timescale 1ns/10ps
module ipsu_core_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire ipsu_pkg::ipsu_cpu_req_s cpu_req,
    input wire logic ack_en,
    input wire logic ret_cmd,
    output logic cpu_ack,
    output logic cpu_return
);
    import ipsu_pkg::*;
    logic [1:0] gap_r;
    // the offer drops two cycles after an ack, so hold off or one request is taken twice
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cpu_ack <= 1'b0;
            cpu_return <= 1'b0;
            gap_r <= 2'h0;
        end
        else
        begin
            cpu_ack <= 1'b0;
            cpu_return <= ret_cmd;
            if (gap_r != 2'h0)
                gap_r <= gap_r - 2'h1;
            else if (ack_en && cpu_req.valid)
            begin
                cpu_ack <= 1'b1;
                gap_r <= 2'h3;
            end
        end
    end
endmodule : ipsu_core_model

/* bench/ipsu_top_tb_top.sv */
`timescale 1ns/10ps
`include "ipsu_consts.svh"
module ipsu_top_tb_top;
    import ipsu_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    ipsu_axi_req_s req = '0;
    ipsu_axi_rsp_s rsp;
    logic [1:0] src_event = 2'h0;
    logic [3:0] trap_event = 4'h0;
    logic cpu_ack, cpu_return, irq;
    logic ack_en = 1'b0;
    logic ret_cmd = 1'b0;
    ipsu_cpu_req_s cpu_req;
    logic [3:0] cpu_level;
    logic [1:0] wq[$];
    logic [33:0] rq[$];
    int n_errors = 0, total_checks = 0, cyc = 0, seed = 96;
    logic [31:0] rv;
    always #4 aclk = ~aclk;
    ipsu_top #(.STACK_DEPTH(8)) i_dut (.aclk(aclk), .aresetn(aresetn), .axi_req(req),
        .axi_rsp(rsp), .src_event(src_event), .trap_event(trap_event), .cpu_ack(cpu_ack),
        .cpu_return(cpu_return), .cpu_req(cpu_req), .cpu_level(cpu_level), .irq(irq));
    ipsu_core_model i_core (.aclk(aclk), .aresetn(aresetn), .cpu_req(cpu_req),
        .ack_en(ack_en), .ret_cmd(ret_cmd), .cpu_ack(cpu_ack), .cpu_return(cpu_return));
    task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic complete_run;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : complete_run
    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask : tick
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
        wq.push_back(er);
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.awaddr <= a;
        req.wdata <= d;
        req.wstrb <= 4'hF;
        req.bready <= 1'b1;
        @(posedge aclk);
        while (rsp.awready !== 1'b1) @(posedge aclk);
        req.awvalid <= 1'b0;
        req.wvalid <= 1'b0;
        @(posedge aclk);
        // bready stays high: dropping it here would clash with the next call raising it
        while (rsp.bvalid !== 1'b1) @(posedge aclk);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
        rq.push_back({er, d});
        req.arvalid <= 1'b1;
        req.araddr <= a;
        req.rready <= 1'b1;
        @(posedge aclk);
        while (rsp.arready !== 1'b1) @(posedge aclk);
        req.arvalid <= 1'b0;
        @(posedge aclk);
        while (rsp.rvalid !== 1'b1) @(posedge aclk);
    endtask : rd
    task automatic ev(input logic [1:0] s, input logic [3:0] t);
        src_event <= s;
        trap_event <= t;
        @(posedge aclk);
        src_event <= 2'h0;
        trap_event <= 4'h0;
        tick(3);
    endtask : ev
    task automatic ret;
        ret_cmd <= 1'b1;
        @(posedge aclk);
        ret_cmd <= 1'b0;
        tick(2);
    endtask : ret
    task automatic wait_lvl(input logic [3:0] l);
        while (cpu_level !== l) @(posedge aclk);
    endtask : wait_lvl
    // responses are judged here, against notes left by the driving tasks
    always @(posedge aclk)
    begin
        if (rsp.bvalid && req.bready)
            chk(rsp.bresp, wq.pop_front());
        if (rsp.rvalid && req.rready)
            chk({rsp.rresp, rsp.rdata}, rq.pop_front());
    end
    always @(posedge aclk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            n_errors++;
            complete_run;
        end
    end
    initial
    begin
        tick(4);
        aresetn <= 1'b1;
        tick(1);
        rd(`IPSU_OFF_PRIO, 16'h0044);
        rd(`IPSU_OFF_STATUS, 16'h0000);
        for (int i = 0; i < 4; i++)
        begin
            rv = $random(seed);
            wr(`IPSU_OFF_PRIO, rv);
            rd(`IPSU_OFF_PRIO, rv & 32'h0000_0077);
        end
        wr(8'h40, 16'h0001, 2'h2);
        rd(8'h40, 16'h0000, 2'h2);
        wr(`IPSU_OFF_PRIO, 16'h0044);
        wr(`IPSU_OFF_FLAGS, 16'h0003);
        wr(`IPSU_OFF_ENABLE, 16'h0003);
        ev(2'h3, 4'h0);
        chk(irq, 1'b1);
        wr(`IPSU_OFF_STATUS, 16'h2000);
        rd(`IPSU_OFF_STATUS, 16'h202D);
        wr(`IPSU_OFF_SRL, 16'h00E0);
        rd(`IPSU_OFF_STATUS, 16'hA72D);
        chk(cpu_req.valid, 1'b0);
        wr(`IPSU_OFF_PRIO, 16'h0045);
        wr(`IPSU_OFF_SRL, 16'h0000);
        ack_en <= 1'b1;
        wait_lvl(4'h5);
        rd(`IPSU_OFF_STATUS, 16'hA52E);
        wr(`IPSU_OFF_FLAGS, 16'h0002);
        rd(`IPSU_OFF_STATUS, 16'hA52D);
        wr(`IPSU_OFF_STATUS, 16'h0000);
        rd(`IPSU_OFF_STATUS, 16'h852E);
        ret;
        wait_lvl(4'h4);
        wr(`IPSU_OFF_FLAGS, 16'h0001);
        ret;
        rd(`IPSU_OFF_STATUS, 16'h002D);
        chk(irq, 1'b0);
        wr(`IPSU_OFF_SRL, 16'h00E0);
        ev(2'h0, 4'h2);
        wait_lvl(4'h9);
        rd(`IPSU_OFF_CTRL1, 16'h0004);
        wr(`IPSU_OFF_CTRL1, 16'h0004);
        rd(`IPSU_OFF_CTRL1, 16'h0000);
        ret;
        chk(cpu_level, 4'h7);
        wr(`IPSU_OFF_SRL, 16'h0000);
        // nesting disabled: a higher source waits until the running service returns
        wr(`IPSU_OFF_CTRL1, 16'h8000);
        ev(2'h1, 4'h0);
        wait_lvl(4'h4);
        ev(2'h2, 4'h0);
        chk(cpu_level, 4'h4);
        rd(`IPSU_OFF_STATUS, 16'h842D);
        wr(`IPSU_OFF_FLAGS, 16'h0001);
        ret;
        wait_lvl(4'h5);
        wr(`IPSU_OFF_FLAGS, 16'h0002);
        ret;
        wait_lvl(4'h0);
        wr(`IPSU_OFF_CTRL1, 16'h0000);
        ack_en <= 1'b0;
        wr(`IPSU_OFF_PRIO, 16'h0060);
        wr(`IPSU_OFF_TIMED_IRQ_DISABLE_INSTR, 16'h00C8);
        ev(2'h3, 4'h0);
        chk(cpu_req.valid, 1'b0);
        wr(`IPSU_OFF_PRIO, 16'h0070);
        tick(3);
        chk({cpu_req.valid, cpu_req.vector}, 9'h135);
        // second reset after the fields were rewritten
        aresetn <= 1'b0;
        tick(4);
        aresetn <= 1'b1;
        tick(1);
        rd(`IPSU_OFF_PRIO, 16'h0044);
        rd(`IPSU_OFF_STATUS, 16'h0000);
        complete_run;
    end
endmodule : ipsu_top_tb_top
